/* File: design/tsl_pkg.sv */
// Shared constants and carriers of the temperature sensor register bank
package tsl_pkg;
  // ----------
  // Timing
  // ----------
  localparam int unsigned CLK_PERIOD_NS = 5;
  localparam int unsigned SOFT_RST_MS = 2;
  localparam int unsigned SOFT_RST_CYC =
    (SOFT_RST_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned TICK_US = 500;
  localparam int unsigned TICK_CYC = TICK_US * 1000 / CLK_PERIOD_NS;
  localparam int unsigned CYCLE_US [8] = '{15500, 125000, 250000,
    500000, 1000000, 4000000, 8000000, 16000000};
  localparam int unsigned AVG_MIN_US [4] = '{0, 125000, 500000, 1000000};
  localparam int unsigned AVG_CONV [4] = '{1, 8, 32, 64};
  localparam int unsigned NVM_LOAD_CYC = 16;
  localparam int unsigned NVM_PROG_CYC = 1000;
  // ----------
  // Register offsets
  // ----------
  localparam logic [7:0] REG_CFG = 8'h01;
  localparam logic [7:0] REG_HI = 8'h02;
  localparam logic [7:0] REG_LO = 8'h03;
  localparam logic [7:0] REG_UNLOCK = 8'h04;
  localparam logic [7:0] REG_SA = 8'h05;
  localparam logic [7:0] REG_SB = 8'h06;
  // ----------
  // Field positions and masks
  // ----------
  localparam int unsigned CFG_BUSY_BIT = 12;
  localparam int unsigned CFG_MOD_LSB = 10;
  localparam int unsigned CFG_CONV_LSB = 7;
  localparam int unsigned CFG_AVG_LSB = 5;
  localparam int unsigned CFG_SRST_BIT = 1;
  localparam int unsigned UNL_EN_BIT = 15;
  localparam int unsigned UNL_BUSY_BIT = 14;
  localparam logic [15:0] CFG_WMASK = 16'h0FFC;
  localparam logic [15:0] CFG_NVM_MASK = 16'h07FC;
  localparam logic [1:0] MODE_SD = 2'h1;
  localparam logic [1:0] MODE_ALT_CC = 2'h2;
  localparam logic [1:0] MODE_OS = 2'h3;
  // ----------
  // Reset and factory values
  // ----------
  localparam logic [15:0] CFG_RST = 16'h0220;
  localparam logic [15:0] HI_RST = 16'h6000;
  localparam logic [15:0] LO_RST = 16'h8000;
  localparam logic [15:0] UNLOCK_RST = 16'h0000;
  localparam logic [15:0] SA_RST = 16'h5A3C; // Arbitrary unique-id stand-in
  localparam logic [15:0] SB_RST = 16'h0000;
  // ----------
  // Two-wire bus and store word indices
  // ----------
  localparam logic [6:0] GC_ADDR = 7'h00;
  localparam logic [7:0] GC_RESET = 8'h06;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [2:0] NVM_CFG = 3'h0;
  localparam logic [2:0] NVM_HI = 3'h1;
  localparam logic [2:0] NVM_LO = 3'h2;
  localparam logic [2:0] NVM_SA = 3'h3;
  localparam logic [2:0] NVM_SB = 3'h4;
  // ----------
  // Carriers
  // ----------
  typedef struct packed {
    logic [15:0] cfg;
    logic [15:0] hi;
    logic [15:0] lo;
    logic [15:0] sa;
    logic [15:0] sb;
  } tsl_image_s;
  typedef struct packed {
    logic valid;
    logic [2:0] idx;
    logic [15:0] data;
  } tsl_prog_s;
endpackage : tsl_pkg

/* File: design/tsl_nvm.sv */
// Non-volatile shadow store with busy timing for reload and programming
`timescale 1ns/10ps
`default_nettype none
module tsl_nvm #(
  parameter int unsigned PROG_CYC = tsl_pkg::NVM_PROG_CYC
) (
  input wire logic clk_i, // Core clock
  input wire logic rst_n_i, // Async reset, active low
  input wire logic reload_i, // Pulse: reload image into registers
  input wire tsl_pkg::tsl_prog_s prog_i, // Program request
  output logic busy_o, // Store busy
  output logic load_done_o, // Pulse: image valid for loading
  output tsl_pkg::tsl_image_s image_o // Stored image
);
  logic [31:0] cnt_q;
  logic busy_q;
  logic loading_q;
  logic done_q;
  tsl_pkg::tsl_image_s image_q;

  // ---------------------------------------------------------------
  // Stored words; reset stands in for factory contents
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      image_q <= '{tsl_pkg::CFG_RST, tsl_pkg::HI_RST, tsl_pkg::LO_RST,
                   tsl_pkg::SA_RST, tsl_pkg::SB_RST};
    end
    else if (!busy_q && !reload_i && prog_i.valid)
    begin
      unique case (prog_i.idx)
        tsl_pkg::NVM_CFG: image_q.cfg <= prog_i.data & tsl_pkg::CFG_NVM_MASK;
        tsl_pkg::NVM_HI: image_q.hi <= prog_i.data;
        tsl_pkg::NVM_LO: image_q.lo <= prog_i.data;
        tsl_pkg::NVM_SA: image_q.sa <= prog_i.data;
        default: image_q.sb <= prog_i.data;
      endcase
    end
  end

  // Busy timing: power-up starts in a reload, requests while busy drop
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      busy_q <= 1'b1;
      loading_q <= 1'b1;
      cnt_q <= tsl_pkg::NVM_LOAD_CYC;
      done_q <= 1'b0;
    end
    else
    begin
      done_q <= 1'b0;
      if (busy_q)
      begin
        cnt_q <= cnt_q - 32'h1;
        if (cnt_q <= 32'h1)
        begin
          busy_q <= 1'b0;
          done_q <= loading_q;
          loading_q <= 1'b0;
        end
      end
      else if (reload_i)
      begin
        busy_q <= 1'b1;
        loading_q <= 1'b1;
        cnt_q <= tsl_pkg::NVM_LOAD_CYC;
      end
      else if (prog_i.valid)
      begin
        busy_q <= 1'b1;
        cnt_q <= PROG_CYC;
      end
    end
  end

  assign busy_o = busy_q;
  assign load_done_o = done_q;
  assign image_o = image_q;
endmodule : tsl_nvm
`default_nettype wire

/* File: design/tsl_cycle_timer.sv */
// Conversion cycle scheduler driven by cycle-time and averaging codes
`timescale 1ns/10ps
`default_nettype none
module tsl_cycle_timer #(
  parameter int unsigned TICK_CYC = tsl_pkg::TICK_CYC
) (
  input wire logic clk_i, // Core clock
  input wire logic rst_n_i, // Async reset, active low
  input wire logic run_i, // Continuous mode active
  input wire logic oneshot_i, // Pulse: single cycle request
  input wire logic [2:0] conv_sel_i, // Cycle-time code
  input wire logic [1:0] avg_sel_i, // Averaging code
  output logic conv_start_o, // Pulse: start of a conversion cycle
  output logic [6:0] avg_count_o // Conversions per result
);
  logic [31:0] tick_q;
  logic [15:0] per_q;
  logic first_q;
  logic start_q;
  logic [6:0] avg_q;
  logic [31:0] sel_us;
  logic [15:0] period;
  logic tick;

  // Averaging floor wins, so a slow average leaves no standby gap
  always_comb
  begin
    sel_us = tsl_pkg::CYCLE_US[conv_sel_i];
    if (tsl_pkg::AVG_MIN_US[avg_sel_i] > sel_us)
    begin
      sel_us = tsl_pkg::AVG_MIN_US[avg_sel_i];
    end
    period = 16'(sel_us / tsl_pkg::TICK_US);
  end

  assign tick = (tick_q >= TICK_CYC - 1);

  // Prescaler and cycle counter; both idle outside continuous mode
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      tick_q <= 32'h0;
      per_q <= 16'h0;
      first_q <= 1'b1;
      start_q <= 1'b0;
      avg_q <= 7'(tsl_pkg::AVG_CONV[tsl_pkg::CFG_RST[6:5]]); // Reset code
    end
    else
    begin
      avg_q <= 7'(tsl_pkg::AVG_CONV[avg_sel_i]);
      start_q <= 1'b0;
      if (!run_i)
      begin
        tick_q <= 32'h0;
        per_q <= 16'h0;
        first_q <= 1'b1;
        start_q <= oneshot_i;
      end
      else if (first_q)
      begin
        first_q <= 1'b0;
        start_q <= 1'b1;
      end
      else
      begin
        tick_q <= tick ? 32'h0 : tick_q + 32'h1;
        if (tick)
        begin
          if (per_q + 16'h1 >= period)
          begin
            per_q <= 16'h0;
            start_q <= 1'b1;
          end
          else
          begin
            per_q <= per_q + 16'h1;
          end
        end
      end
    end
  end

  assign conv_start_o = start_q;
  assign avg_count_o = avg_q;
endmodule : tsl_cycle_timer
`default_nettype wire

/* File: design/tsl_sensor_regs.sv */
// Two-wire slave and register bank of the temperature sensor
`timescale 1ns/10ps
`default_nettype none
// Functional notes
// - Writing soft reset bit starts 2 ms reset
// - Soft reset bit always reads zero
// - Cycle period from cycle-time and averaging codes
// - Slow averaging removes standby, cycles back-to-back
// - Thresholds signed 16-bit, compared to temperature
// - Upper threshold reloads from store after reset
// - Lower threshold reloads from store after reset
// - Locked writes touch only volatile registers
// - Unlocked writes also program the store
// - Unlock busy bit mirrors configuration busy bit
// - Busy high during programming or reload
// - Scratch word A shadowed in store
// - Scratch preloaded with id; host keeps first
// - Scratch word B behaves like scratch A
// - Averaging code selects 1, 8, 32, 64
module tsl_sensor_regs #(
  parameter logic [6:0] SLAVE_ADDR = 7'h48,
  parameter int unsigned SOFT_RST_CYC = tsl_pkg::SOFT_RST_CYC,
  parameter int unsigned TICK_CYC = tsl_pkg::TICK_CYC,
  parameter int unsigned NVM_PROG_CYC = tsl_pkg::NVM_PROG_CYC
) (
  input wire logic clk_i, // Core clock, 200 MHz
  input wire logic rst_n_i, // Async power-up reset, active low
  input wire logic scl_i, // Bus clock pin level
  input wire logic sda_i, // Bus data pin level
  output logic sda_o, // Bus data drive value, always low
  output logic sda_oen_o, // Bus data enable, low drives the pin
  input wire logic [15:0] temp_i, // Latest temperature result
  output logic above_upper_o, // Temperature above upper threshold
  output logic below_lower_o, // Temperature below lower threshold
  output logic conv_start_o, // Pulse: start a conversion cycle
  output logic [6:0] avg_count_o, // Conversions accumulated per result
  output logic soft_reset_o // Internal soft reset in progress
);
  // ----------
  // Declarations
  // ----------
  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_RX = 5'b00010,
    ST_ACK = 5'b00100,
    ST_TX = 5'b01000,
    ST_MACK = 5'b10000
  } tsl_bus_e;

  tsl_bus_e state_q;
  logic [1:0] scl_sync_q;
  logic [1:0] sda_sync_q;
  logic scl_p_q;
  logic sda_p_q;
  logic scl_rise;
  logic scl_fall;
  logic bus_start;
  logic bus_stop;
  logic [7:0] shift_q;
  logic [3:0] bitcnt_q;
  logic [1:0] byte_no_q;
  logic rw_q;
  logic gc_q;
  logic acked_q;
  logic more_q;
  logic rd_lsb_q;
  logic oen_q;
  logic [7:0] ptr_q;
  logic [7:0] msb_q;
  logic wr_stb;
  logic [15:0] wr_data;
  logic gc_reset;
  logic [15:0] cfg_q;
  logic [15:0] hi_q;
  logic [15:0] lo_q;
  logic unlock_q;
  logic [15:0] sa_q;
  logic [15:0] sb_q;
  logic [15:0] rd_word;
  logic [7:0] tx_byte;
  logic addr_hit;
  logic [31:0] srst_cnt_q;
  logic srst_q;
  logic srst_req;
  logic reload_req;
  logic nvm_busy;
  logic nvm_done;
  logic oneshot_q;
  logic above_q;
  logic below_q;
  tsl_pkg::tsl_image_s image;
  tsl_pkg::tsl_prog_s prog;

  // ----------
  // Pin synchronisers and bus conditions
  // ----------
  // Pins are asynchronous, so both pass two flops before any edge logic
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      scl_sync_q <= 2'h3;
      sda_sync_q <= 2'h3;
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
    end
    else
    begin
      scl_sync_q <= {scl_sync_q[0], scl_i};
      sda_sync_q <= {sda_sync_q[0], sda_i};
      scl_p_q <= scl_sync_q[1];
      sda_p_q <= sda_sync_q[1];
    end
  end

  assign scl_rise = scl_sync_q[1] & ~scl_p_q;
  assign scl_fall = ~scl_sync_q[1] & scl_p_q;
  assign bus_start = scl_sync_q[1] & scl_p_q & sda_p_q & ~sda_sync_q[1];
  assign bus_stop = scl_sync_q[1] & scl_p_q & ~sda_p_q & sda_sync_q[1];
  assign addr_hit = (shift_q[7:1] == SLAVE_ADDR) ||
                    (shift_q[7:1] == tsl_pkg::GC_ADDR && !shift_q[0]);

  // ----------
  // Read multiplexer
  // ----------
  // Alert and data-ready flags live elsewhere and read zero here
  always_comb
  begin
    rd_word = 16'h0000;
    unique case (ptr_q)
      tsl_pkg::REG_CFG:
      begin
        rd_word = cfg_q; // Soft reset bit never stored
        rd_word[tsl_pkg::CFG_BUSY_BIT] = nvm_busy;
        if (cfg_q[11:10] == tsl_pkg::MODE_ALT_CC)
        begin
          rd_word[11:10] = 2'h0; // Alias of continuous mode reads 00
        end
      end
      tsl_pkg::REG_HI: rd_word = hi_q;
      tsl_pkg::REG_LO: rd_word = lo_q;
      tsl_pkg::REG_UNLOCK:
      begin
        rd_word[tsl_pkg::UNL_EN_BIT] = unlock_q;
        rd_word[tsl_pkg::UNL_BUSY_BIT] = nvm_busy;
      end
      tsl_pkg::REG_SA: rd_word = sa_q;
      tsl_pkg::REG_SB: rd_word = sb_q;
      default: rd_word = 16'h0000;
    endcase
    tx_byte = rd_lsb_q ? rd_word[7:0] : rd_word[15:8];
  end

  // ----------
  // Serial engine
  // ----------
  // Data bits change only after a falling clock, so the master samples
  // stable data; start and stop override any state
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      state_q <= ST_IDLE;
      shift_q <= 8'h00;
      bitcnt_q <= 4'h0;
      byte_no_q <= 2'h0;
      rw_q <= 1'b0;
      gc_q <= 1'b0;
      acked_q <= 1'b0;
      more_q <= 1'b0;
      rd_lsb_q <= 1'b0;
      oen_q <= 1'b1;
    end
    else if (bus_stop)
    begin
      state_q <= ST_IDLE;
      oen_q <= 1'b1;
    end
    else if (bus_start)
    begin
      state_q <= ST_RX;
      bitcnt_q <= 4'h0;
      byte_no_q <= 2'h0;
      gc_q <= 1'b0;
      oen_q <= 1'b1;
    end
    else
    begin
      unique case (state_q)
        ST_IDLE: oen_q <= 1'b1;
        ST_RX:
        begin
          if (scl_rise && bitcnt_q < tsl_pkg::BITS_PER_BYTE)
          begin
            shift_q <= {shift_q[6:0], sda_sync_q[1]};
            bitcnt_q <= bitcnt_q + 4'h1;
          end
          else if (scl_fall && bitcnt_q == tsl_pkg::BITS_PER_BYTE)
          begin
            state_q <= ST_ACK;
            acked_q <= (byte_no_q != 2'h0) || addr_hit;
            oen_q <= ~((byte_no_q != 2'h0) || addr_hit);
            if (byte_no_q == 2'h0)
            begin
              rw_q <= shift_q[0];
              gc_q <= (shift_q[7:1] == tsl_pkg::GC_ADDR);
              rd_lsb_q <= 1'b0;
            end
            byte_no_q <= (byte_no_q == 2'h3) ? 2'h2 : byte_no_q + 2'h1;
          end
        end
        ST_ACK:
        begin
          if (scl_fall)
          begin
            bitcnt_q <= 4'h0;
            if (!acked_q)
            begin
              state_q <= ST_IDLE;
              oen_q <= 1'b1;
            end
            else if (rw_q && byte_no_q == 2'h1)
            begin
              state_q <= ST_TX;
              shift_q <= tx_byte;
              oen_q <= tx_byte[7];
            end
            else
            begin
              state_q <= ST_RX;
              oen_q <= 1'b1;
            end
          end
        end
        ST_TX:
        begin
          if (scl_rise)
          begin
            bitcnt_q <= bitcnt_q + 4'h1;
          end
          else if (scl_fall && bitcnt_q == tsl_pkg::BITS_PER_BYTE)
          begin
            state_q <= ST_MACK;
            oen_q <= 1'b1;
            rd_lsb_q <= ~rd_lsb_q;
          end
          else if (scl_fall)
          begin
            shift_q <= {shift_q[6:0], 1'b0};
            oen_q <= shift_q[6];
          end
        end
        ST_MACK:
        begin
          if (scl_rise)
          begin
            more_q <= ~sda_sync_q[1];
          end
          else if (scl_fall && more_q)
          begin
            state_q <= ST_TX;
            bitcnt_q <= 4'h0;
            shift_q <= tx_byte;
            oen_q <= tx_byte[7];
          end
          else if (scl_fall)
          begin
            state_q <= ST_IDLE;
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // Byte decode: pointer, data bytes and the general-call reset command
  assign wr_stb = (state_q == ST_RX) && scl_fall && !gc_q && !rw_q &&
                  bitcnt_q == tsl_pkg::BITS_PER_BYTE && byte_no_q == 2'h3;
  assign wr_data = {msb_q, shift_q};
  assign gc_reset = (state_q == ST_RX) && scl_fall && gc_q &&
                    bitcnt_q == tsl_pkg::BITS_PER_BYTE &&
                    byte_no_q == 2'h1 && shift_q == tsl_pkg::GC_RESET;

  // Pointer and high data byte capture
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      ptr_q <= 8'h00;
      msb_q <= 8'h00;
    end
    else if (srst_req || gc_reset)
    begin
      ptr_q <= 8'h00;
    end
    else if ((state_q == ST_RX) && scl_fall && !gc_q && !rw_q &&
             bitcnt_q == tsl_pkg::BITS_PER_BYTE)
    begin
      if (byte_no_q == 2'h1)
      begin
        ptr_q <= shift_q;
      end
      else if (byte_no_q == 2'h2)
      begin
        msb_q <= shift_q;
      end
    end
  end

  // ----------
  // Register bank
  // ----------
  // Volatile copies take every write; the store reload overrides them
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      cfg_q <= tsl_pkg::CFG_RST;
      hi_q <= tsl_pkg::HI_RST;
      lo_q <= tsl_pkg::LO_RST;
      sa_q <= tsl_pkg::SA_RST;
      sb_q <= tsl_pkg::SB_RST;
      oneshot_q <= 1'b0;
    end
    else if (nvm_done)
    begin
      cfg_q <= image.cfg & tsl_pkg::CFG_NVM_MASK;
      hi_q <= image.hi;
      lo_q <= image.lo;
      sa_q <= image.sa;
      sb_q <= image.sb;
      oneshot_q <= 1'b0;
    end
    else
    begin
      oneshot_q <= 1'b0;
      if (wr_stb)
      begin
        unique case (ptr_q)
          tsl_pkg::REG_CFG:
          begin
            cfg_q <= wr_data & tsl_pkg::CFG_WMASK;
            oneshot_q <= (wr_data[11:10] == tsl_pkg::MODE_OS);
          end
          tsl_pkg::REG_HI: hi_q <= wr_data;
          tsl_pkg::REG_LO: lo_q <= wr_data;
          tsl_pkg::REG_SA: sa_q <= wr_data;
          tsl_pkg::REG_SB: sb_q <= wr_data;
          default: ;
        endcase
      end
      else if (oneshot_q)
      begin
        cfg_q[11:10] <= tsl_pkg::MODE_SD; // One-shot falls back to shutdown
      end
    end
  end

  // Unlock bit; other bits of that word are not stored
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      unlock_q <= tsl_pkg::UNLOCK_RST[tsl_pkg::UNL_EN_BIT];
    end
    else if (srst_req || gc_reset)
    begin
      unlock_q <= tsl_pkg::UNLOCK_RST[tsl_pkg::UNL_EN_BIT];
    end
    else if (wr_stb && ptr_q == tsl_pkg::REG_UNLOCK)
    begin
      unlock_q <= wr_data[tsl_pkg::UNL_EN_BIT];
    end
  end

  // Program request only while unlocked and only for backed registers
  always_comb
  begin
    prog = '0;
    prog.data = wr_data;
    prog.valid = wr_stb && unlock_q;
    unique case (ptr_q)
      tsl_pkg::REG_CFG: prog.idx = tsl_pkg::NVM_CFG;
      tsl_pkg::REG_HI: prog.idx = tsl_pkg::NVM_HI;
      tsl_pkg::REG_LO: prog.idx = tsl_pkg::NVM_LO;
      tsl_pkg::REG_SA: prog.idx = tsl_pkg::NVM_SA;
      tsl_pkg::REG_SB: prog.idx = tsl_pkg::NVM_SB;
      default: prog.valid = 1'b0;
    endcase
  end

  // ----------
  // Soft reset and reload
  // ----------
  assign srst_req = wr_stb && ptr_q == tsl_pkg::REG_CFG &&
                    wr_data[tsl_pkg::CFG_SRST_BIT];
  assign reload_req = srst_req || gc_reset;

  // Conversions stay halted for the full reset window
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      srst_q <= 1'b0;
      srst_cnt_q <= 32'h0;
    end
    else if (srst_req)
    begin
      srst_q <= 1'b1;
      srst_cnt_q <= SOFT_RST_CYC - 1;
    end
    else if (srst_q)
    begin
      srst_cnt_q <= srst_cnt_q - 32'h1;
      srst_q <= (srst_cnt_q != 32'h0);
    end
  end

  tsl_nvm #(
    .PROG_CYC(NVM_PROG_CYC)
  ) u_nvm (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .reload_i(reload_req),
    .prog_i(prog),
    .busy_o(nvm_busy),
    .load_done_o(nvm_done),
    .image_o(image)
  );

  tsl_cycle_timer #(
    .TICK_CYC(TICK_CYC)
  ) u_timer (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .run_i(!srst_q && !cfg_q[10]),
    .oneshot_i(oneshot_q && !srst_q),
    .conv_sel_i(cfg_q[tsl_pkg::CFG_CONV_LSB +: 3]),
    .avg_sel_i(cfg_q[tsl_pkg::CFG_AVG_LSB +: 2]),
    .conv_start_o(conv_start_o),
    .avg_count_o(avg_count_o)
  );

  // ----------
  // Threshold comparison
  // ----------
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      above_q <= 1'b0;
      below_q <= 1'b0;
    end
    else
    begin
      above_q <= $signed(temp_i) > $signed(hi_q);
      below_q <= $signed(temp_i) < $signed(lo_q);
    end
  end

  assign above_upper_o = above_q;
  assign below_lower_o = below_q;
  assign soft_reset_o = srst_q;
  assign sda_o = 1'b0;
  assign sda_oen_o = oen_q;
endmodule : tsl_sensor_regs
`default_nettype wire

/* File: tb/tsl_sensor_regs_monitor.sv */
// Port checker of the sensor register bank
`timescale 1ns/10ps
`default_nettype none
module tsl_sensor_regs_monitor #(
  parameter int unsigned SOFT_RST_CYC = 50
) (
  input wire logic clk_i, // Core clock
  input wire logic rst_n_i, // Reset, active low
  input wire logic sda_o, // Data drive value
  input wire logic [15:0] temp_i, // Temperature
  input wire logic above_upper_o, // Above upper
  input wire logic below_lower_o, // Below lower
  input wire logic conv_start_o, // Cycle start
  input wire logic [6:0] avg_count_o, // Averaging count
  input wire logic soft_reset_o // Soft reset level
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  logic [31:0] srst_q;
  // Length of the current soft reset, cleared between runs
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      srst_q <= '0;
    else
      srst_q <= soft_reset_o ? srst_q + 1 : '0;
  end
  sequence s_srst_run;
    soft_reset_o [*2];
  endsequence
  a_drive_low: assert property (sda_o == 1'b0) else $error("sda drive");
  a_srst_len: assert property ($fell(soft_reset_o) |->
    srst_q == SOFT_RST_CYC) else $error("soft reset length");
  a_srst_hold: assert property ($rose(soft_reset_o) |->
    s_srst_run) else $error("soft reset short");
  a_above_floor: assert property (temp_i == 16'h8000 |=>
    !above_upper_o) else $error("above at floor");
  a_below_ceil: assert property (temp_i == 16'h7FFF |=>
    !below_lower_o) else $error("below at ceiling");
  a_avg_legal: assert property (avg_count_o inside
    {7'h01, 7'h08, 7'h20, 7'h40}) else $error("avg count");
  a_avg_reset: assert property (!$past(rst_n_i) |->
    avg_count_o == 7'h08) else $error("avg after reset");
  a_start_pulse: assert property (conv_start_o |=>
    !conv_start_o) else $error("start pulse");
endmodule : tsl_sensor_regs_monitor
bind tsl_sensor_regs tsl_sensor_regs_monitor #(
  .SOFT_RST_CYC(SOFT_RST_CYC)) tsl_sensor_regs_monitor_inst (
  .clk_i(clk_i), .rst_n_i(rst_n_i), .sda_o(sda_o), .temp_i(temp_i),
  .above_upper_o(above_upper_o), .below_lower_o(below_lower_o),
  .conv_start_o(conv_start_o), .avg_count_o(avg_count_o),
  .soft_reset_o(soft_reset_o));
`default_nettype wire

/* File: tb/tsl_host_model.sv */
// Two-wire bus host that reads and writes device registers
`timescale 1ns/10ps
`default_nettype none
module tsl_host_model #(
  parameter logic [6:0] ADDR = 7'h48
) (
  input wire logic clk_i, // Core clock
  input wire logic sda_i, // Resolved data line
  output logic scl_o, // Bus clock
  output logic sda_o // Data drive, 1 releases
);
  initial
  begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end
  // Ten cycles a phase keeps well clear of the sync delay
  task automatic ph();
    repeat (10) @(posedge clk_i);
  endtask : ph
  task automatic bitx(input logic b, output logic r);
    sda_o <= b;
    ph();
    scl_o <= 1'b1;
    ph();
    r = sda_i;
    scl_o <= 1'b0;
    ph();
  endtask : bitx
  task automatic start();
    sda_o <= 1'b1;
    ph();
    scl_o <= 1'b1;
    ph();
    sda_o <= 1'b0;
    ph();
    scl_o <= 1'b0;
  endtask : start
  task automatic stop();
    sda_o <= 1'b0;
    ph();
    scl_o <= 1'b1;
    ph();
    sda_o <= 1'b1;
    ph();
  endtask : stop
  // MSB first, then the acknowledge slot
  task automatic xfer(input logic [7:0] d, input logic last,
    output logic [7:0] q);
    logic a;
    for (int i = 7; i >= 0; i--)
      bitx(d[i], q[i]);
    bitx(last, a);
  endtask : xfer
  task automatic wr(input logic [7:0] ptr, input logic [15:0] d);
    logic [7:0] q;
    start();
    xfer({ADDR, 1'b0}, 1'b1, q);
    xfer(ptr, 1'b1, q);
    xfer(d[15:8], 1'b1, q);
    xfer(d[7:0], 1'b1, q);
    stop();
  endtask : wr
  task automatic rd(input logic [7:0] ptr, output logic [15:0] d);
    logic [7:0] q;
    start();
    xfer({ADDR, 1'b0}, 1'b1, q);
    xfer(ptr, 1'b1, q);
    start();
    xfer({ADDR, 1'b1}, 1'b1, q);
    xfer(8'hFF, 1'b0, d[15:8]);
    xfer(8'hFF, 1'b1, d[7:0]);
    stop();
  endtask : rd
endmodule : tsl_host_model
`default_nettype wire

/* File: tb/tsl_sensor_regs_test.sv */
// Self-checking bench of the sensor register bank
`timescale 1ns/10ps
`default_nettype none
module tsl_sensor_regs_test;
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [15:0] temp_i = 16'h0000;
  logic scl, hsda, dsda, doen, above, below, cstart, srst;
  logic [6:0] avg;
  logic [15:0] rdat, n;
  wire logic sda_w;
  int err_total = 0;
  int samples_checked = 0;
  // Threshold stimulus and expected start gaps at four cycles a tick
  localparam logic [15:0] TEMPS [4] = '{16'hFE00, 16'h6001, 16'h8000,
    16'h7FFF};
  localparam logic [15:0] GAPS [4] = '{16'h007C, 16'h03E8, 16'h0FA0,
    16'h1F40};
  always #2.5 clk_i = ~clk_i;
  // Open drain with pull-up: low if either side pulls
  assign sda_w = hsda & (doen | dsda);
  tsl_sensor_regs #(.SOFT_RST_CYC(200), .TICK_CYC(4), .NVM_PROG_CYC(4000))
    tsl_sensor_regs_inst (.clk_i(clk_i), .rst_n_i(rst_n_i), .scl_i(scl),
    .sda_i(sda_w), .sda_o(dsda), .sda_oen_o(doen), .temp_i(temp_i),
    .above_upper_o(above), .below_lower_o(below), .conv_start_o(cstart),
    .avg_count_o(avg), .soft_reset_o(srst));
  tsl_host_model tsl_host_model_inst (.clk_i(clk_i), .sda_i(sda_w),
    .scl_o(scl), .sda_o(hsda));
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      err_total++;
      $display("[FAIL] %0t seen %h exp %h", $time, seen, exp);
    end
  endtask : chk
  task automatic rchk(input logic [7:0] ptr, input logic [15:0] exp);
    tsl_host_model_inst.rd(ptr, rdat);
    chk(rdat, exp);
  endtask : rchk
  task automatic wr(input logic [7:0] ptr, input logic [15:0] d);
    tsl_host_model_inst.wr(ptr, d);
  endtask : wr
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : tally_and_finish
  // Cycles between two starts; a missing start ends the run
  task automatic gap();
    int s;
    s = 0;
    n = '0;
    for (int k = 0; k < 20000 && s < 2; k++)
    begin
      @(negedge clk_i);
      n = (s == 1) ? n + 1 : n;
      s = (cstart === 1'b1) ? s + 1 : s;
    end
    if (s < 2)
    begin
      err_total++;
      tally_and_finish();
    end
  endtask : gap
  initial
  begin
    repeat (2) @(posedge clk_i);
    rst_n_i <= 1'b1;
    repeat (40) @(posedge clk_i);
    rchk(tsl_pkg::REG_HI, 16'h6000);
    rchk(tsl_pkg::REG_LO, 16'h8000);
    rchk(tsl_pkg::REG_SA, tsl_pkg::SA_RST);
    rchk(tsl_pkg::REG_SB, 16'h0000);
    $display("test reset values done");
    wr(tsl_pkg::REG_HI, 16'h1234);
    rchk(tsl_pkg::REG_HI, 16'h1234);
    wr(tsl_pkg::REG_UNLOCK, 16'h7FFF);
    rchk(tsl_pkg::REG_UNLOCK, 16'h0000);
    wr(tsl_pkg::REG_CFG, 16'h0222);
    chk({15'h0, srst}, 16'h0001);
    repeat (300) @(posedge clk_i);
    rchk(tsl_pkg::REG_CFG, 16'h0220);
    rchk(tsl_pkg::REG_HI, 16'h6000);
    $display("test locked write done");
    wr(tsl_pkg::REG_UNLOCK, 16'h8000);
    wr(tsl_pkg::REG_SB, 16'hBEEF); // scratch A left alone
    rchk(tsl_pkg::REG_CFG, 16'h1220);
    rchk(tsl_pkg::REG_UNLOCK, 16'hC000);
    repeat (4000) @(posedge clk_i);
    rchk(tsl_pkg::REG_UNLOCK, 16'h8000);
    wr(tsl_pkg::REG_UNLOCK, 16'h0000);
    wr(tsl_pkg::REG_SB, 16'h1111);
    wr(tsl_pkg::REG_CFG, 16'h0222);
    repeat (300) @(posedge clk_i);
    rchk(tsl_pkg::REG_SB, 16'hBEEF);
    $display("test unlocked write done");
    wr(tsl_pkg::REG_LO, 16'hFF00);
    for (int i = 0; i < 4; i++)
    begin
      @(posedge clk_i);
      temp_i <= TEMPS[i];
      repeat (2) @(negedge clk_i);
      chk({14'h0, above, below}, {14'h0, i[0], !i[0]});
    end
    $display("test thresholds done");
    for (int a = 0; a < 4; a++)
    begin
      wr(tsl_pkg::REG_CFG, {9'h000, a[1:0], 5'h00});
      chk({9'h000, avg}, 16'(tsl_pkg::AVG_CONV[a]));
      gap();
      chk(n, GAPS[a]);
    end
    $display("test cycle period done");
    tally_and_finish();
  end
endmodule : tsl_sensor_regs_test
`default_nettype wire
